// file: src/two_wire_cfg.svh
`ifndef TWO_WIRE_CFG_SVH
`define TWO_WIRE_CFG_SVH

// slave addresses picked by the three address straps
`define ADDR_LOW_00 7'h61
`define ADDR_LOW_01 7'h62
`define ADDR_LOW_10 7'h64
`define ADDR_LOW_11 7'h65
`define ADDR_HIGH_PREFIX 5'h0B

// high-speed master code is 00001xxx
`define HS_CODE_PREFIX 5'h01

// bit counter value at the end of a byte
`define BYTE_BITS 4'h8

// write byte phases inside a word
`define PHASE_POINTER 2'h0
`define PHASE_HIGH 2'h1
`define PHASE_LOW 2'h2

// reset values
`define POINTER_RESET 8'h00
`define SNAPSHOT_RESET 16'h0000

// fastest bus: 3.4 Mbps gives about 294 ns per bit
`define HS_BIT_NS 294
`define CLK_NS 10
`define HS_BIT_CYCLES (`HS_BIT_NS / `CLK_NS)

`endif

// file: src/two_wire_pkg.sv
package two_wire_pkg;

   // protocol states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_SACK = 6'h04,
      ST_RX = 6'h08,
      ST_TX = 6'h10,
      ST_MACK = 6'h20
   } state_t;

   // one register write toward the register file
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [15:0] data;
   } reg_write_t;

   // synchronised bus and strap levels
   typedef struct packed {
      logic scl;
      logic sda;
      logic sel;
      logic first;
      logic second;
      logic third;
   } pins_t;

endpackage

// file: src/two_wire_register_slave.sv
`timescale 1ns/1ns
`include "two_wire_cfg.svh"

// Behaviour
// - strap low enables two-wire port; strap high enables the four-wire port instead.
// - only 7-bit addresses decode; no 10-bit or general call response.
// - slave address comes from the three address straps per the address table.
// - start is SDA falling while SCL high; it opens every transfer.
// - stop is SDA rising while SCL high; bus free, wait for start.
// - acknowledge only own address, holding SDA low through ninth clock.
// - each unit is eight data bits plus one acknowledge, unlimited count.
// - master code 00001xxx is recognised, not acknowledged, enters high-speed mode.
// - after repeated start run normally at high speed; stop leaves it.
// - an 8-bit pointer selects the register accessed by data bytes.
// - registers are 16 bits, moved high byte first then low byte.
// - write holds high byte; whole register updates when low byte arrives.
// - read snapshots the register at high byte, kept until low byte sent.
// - pointer never advances; set by write address plus one pointer byte.
// - write is start, address, pointer, high, low, stop; all bytes acknowledged.
// - pointer, high, low triples may repeat within one write transfer.
// - works at 100 kbps, 400 kbps and 3.4 Mbps.
// - device is slave only; never drives SCL or addresses.
// - read sets pointer, repeated start, read address, bytes until master nack.
module two_wire_register_slave (
   input wire logic clk,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic iface_select_strap,
   input wire logic addr_strap_first,
   input wire logic addr_strap_second,
   input wire logic addr_strap_third,
   output logic four_wire_enable,
   output logic hs_mode,
   output logic [7:0] reg_addr,
   input wire logic [15:0] reg_rdata,
   output two_wire_pkg::reg_write_t reg_write
);

   two_wire_pkg::pins_t meta;
   two_wire_pkg::pins_t sync;
   two_wire_pkg::pins_t last;

   // two flops on every pin, then a third stage kept only for edge finding
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= '1;
         sync <= '1;
         last <= '1;
      end else begin
         meta <= {scl_in, sda_in, iface_select_strap, addr_strap_first,
                  addr_strap_second, addr_strap_third};
         sync <= meta;
         last <= sync;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [6:0] own_addr;

   // conditions seen on the synchronised lines; both lines share the same delay
   assign scl_rise = sync.scl & ~last.scl;
   assign scl_fall = ~sync.scl & last.scl;
   assign start_det = sync.scl & last.scl & last.sda & ~sync.sda;
   assign stop_det = sync.scl & last.scl & ~last.sda & sync.sda;

   // address lookup follows the strap table, not a plain concatenation
   always_comb begin
      if (sync.first) begin
         own_addr = {`ADDR_HIGH_PREFIX, sync.second, sync.third};
      end else begin
         unique case ({sync.second, sync.third})
            2'h0: own_addr = `ADDR_LOW_00;
            2'h1: own_addr = `ADDR_LOW_01;
            2'h2: own_addr = `ADDR_LOW_10;
            2'h3: own_addr = `ADDR_LOW_11;
         endcase
      end
   end

   two_wire_pkg::state_t state;
   two_wire_pkg::state_t next_state;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic read_dir;
   logic next_read_dir;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [7:0] pointer;
   logic [7:0] next_pointer;
   logic [7:0] hold;
   logic [7:0] next_hold;
   logic [15:0] snapshot;
   logic [15:0] next_snapshot;
   logic tx_low;
   logic next_tx_low;
   logic next_sda_oe;
   logic next_hs_mode;
   logic next_four_wire;
   two_wire_pkg::reg_write_t next_reg_write;
   logic [7:0] tx_byte;
   logic hs_seen;
   logic addr_match;

   assign tx_byte = tx_low ? snapshot[7:0] : snapshot[15:8];
   // 10-bit prefixes and general call never equal a table address
   // decoded from the held shift value, not the next one, to avoid a loop through the engine
   assign addr_match = (shift[7:1] == own_addr);
   assign hs_seen = (shift[7:3] == `HS_CODE_PREFIX);

   // protocol engine: the device only ever pulls SDA low, SCL is never driven
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_read_dir = read_dir;
      next_phase = phase;
      next_pointer = pointer;
      next_hold = hold;
      next_snapshot = snapshot;
      next_tx_low = tx_low;
      next_sda_oe = sda_oe;
      next_hs_mode = hs_mode;
      next_four_wire = sync.sel;
      next_reg_write = '0;
      if (scl_rise) begin
         next_shift = {shift[6:0], sync.sda};
      end
      if (sync.sel) begin
         // four-wire port selected: this port stays silent
         next_state = two_wire_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
         next_phase = `PHASE_POINTER;
      end else if (stop_det) begin
         // bus free; an unpaired high byte is dropped here
         next_state = two_wire_pkg::ST_IDLE;
         next_sda_oe = 1'b0;
         next_hs_mode = 1'b0;
         next_phase = `PHASE_POINTER;
      end else if (start_det) begin
         // start or repeated start; speed mode is kept across repeats
         next_state = two_wire_pkg::ST_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
         next_phase = `PHASE_POINTER;
         next_tx_low = 1'b0;
      end else begin
         unique case (state)
            two_wire_pkg::ST_IDLE: begin
               next_sda_oe = 1'b0;
            end
            two_wire_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == `BYTE_BITS) begin
                  next_shift = shift;
                  if (addr_match) begin
                     next_state = two_wire_pkg::ST_SACK;
                     next_sda_oe = 1'b1;
                     next_read_dir = shift[0];
                  end else if (hs_seen) begin
                     // master code: no acknowledge, switch speed
                     next_hs_mode = 1'b1;
                     next_state = two_wire_pkg::ST_IDLE;
                  end else begin
                     next_state = two_wire_pkg::ST_IDLE;
                  end
               end
            end
            two_wire_pkg::ST_SACK: begin
               // low held from the eighth fall to the ninth fall
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (read_dir) begin
                     next_state = two_wire_pkg::ST_TX;
                     next_snapshot = reg_rdata;
                     next_tx_low = 1'b0;
                     next_sda_oe = ~reg_rdata[15];
                  end else begin
                     next_state = two_wire_pkg::ST_RX;
                     next_sda_oe = 1'b0;
                  end
               end
            end
            two_wire_pkg::ST_RX: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == `BYTE_BITS) begin
                  next_shift = shift;
                  next_state = two_wire_pkg::ST_SACK;
                  next_sda_oe = 1'b1;
                  unique case (phase)
                     `PHASE_POINTER: begin
                        next_pointer = shift;
                        next_phase = `PHASE_HIGH;
                     end
                     `PHASE_HIGH: begin
                        next_hold = shift;
                        next_phase = `PHASE_LOW;
                     end
                     default: begin
                        // whole word lands at once; next byte is a pointer again
                        next_reg_write.valid = 1'b1;
                        next_reg_write.addr = pointer;
                        next_reg_write.data = {hold, shift};
                        next_phase = `PHASE_POINTER;
                     end
                  endcase
               end
            end
            two_wire_pkg::ST_TX: begin
               if (scl_rise) begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall) begin
                  if (bit_cnt == `BYTE_BITS) begin
                     next_state = two_wire_pkg::ST_MACK;
                     next_sda_oe = 1'b0;
                  end else begin
                     next_sda_oe = ~tx_byte[3'h7 - bit_cnt[2:0]];
                  end
               end
            end
            two_wire_pkg::ST_MACK: begin
               if (scl_rise && sync.sda) begin
                  // master nack ends the read; wait for stop or start
                  next_state = two_wire_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  next_state = two_wire_pkg::ST_TX;
                  if (tx_low) begin
                     // same register again: fresh snapshot
                     next_tx_low = 1'b0;
                     next_snapshot = reg_rdata;
                     next_sda_oe = ~reg_rdata[15];
                  end else begin
                     next_tx_low = 1'b1;
                     next_sda_oe = ~snapshot[7];
                  end
               end
            end
            default: begin
               next_state = two_wire_pkg::ST_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
   end

   // registers of the protocol engine; edge handling at 10 ns keeps 3.4 Mbps
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state <= two_wire_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         read_dir <= 1'b0;
         phase <= `PHASE_POINTER;
         pointer <= `POINTER_RESET;
         hold <= 8'h00;
         snapshot <= `SNAPSHOT_RESET;
         tx_low <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         hs_mode <= 1'b0;
         four_wire_enable <= 1'b0;
         reg_addr <= `POINTER_RESET;
         reg_write <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         read_dir <= next_read_dir;
         phase <= next_phase;
         pointer <= next_pointer;
         hold <= next_hold;
         snapshot <= next_snapshot;
         tx_low <= next_tx_low;
         sda_oe <= next_sda_oe;
         sda_out <= 1'b0;
         hs_mode <= next_hs_mode;
         four_wire_enable <= next_four_wire;
         reg_addr <= next_pointer;
         reg_write <= next_reg_write;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_stop;
      stop_det && !sync.sel;
   endsequence

   sequence s_start;
      start_det && !sync.sel && !stop_det;
   endsequence

   sequence s_byte_end;
      scl_fall && bit_cnt == `BYTE_BITS;
   endsequence

   a_strap_silences: assert property (sync.sel |=> !sda_oe && four_wire_enable)
      else $error("two-wire port active while four-wire port selected");

   a_start_opens: assert property (s_start |=> state == two_wire_pkg::ST_ADDR && bit_cnt == 4'h0)
      else $error("start did not open address phase");

   a_stop_frees: assert property (s_stop |=> state == two_wire_pkg::ST_IDLE && !sda_oe && !hs_mode)
      else $error("stop did not free the bus");

   a_ack_own_only: assert property ((s_byte_end and (state == two_wire_pkg::ST_ADDR
      && !start_det && !stop_det)) |=> sda_oe == (shift[7:1] == own_addr))
      else $error("address acknowledge does not match own address");

   a_ack_held: assert property (state == two_wire_pkg::ST_SACK && !scl_fall
      && !start_det && !stop_det && !sync.sel |=> sda_oe)
      else $error("acknowledge released early");

   a_hs_code: assert property ((s_byte_end and (state == two_wire_pkg::ST_ADDR
      && !start_det && !stop_det && !sync.sel && shift[7:3] == `HS_CODE_PREFIX))
      |=> hs_mode && !sda_oe)
      else $error("master code not taken as high-speed entry");

   a_write_pair: assert property (reg_write.valid |-> reg_write.data[15:8] == $past(hold, 1)
      && $past(phase, 1) == `PHASE_LOW && phase == `PHASE_POINTER)
      else $error("register write without held high byte");

   a_pointer_stays: assert property (phase != `PHASE_POINTER || state != two_wire_pkg::ST_RX
      |=> $stable(pointer))
      else $error("pointer moved outside a pointer byte");

   // the risky spot is the master acknowledge between high and low byte
   a_snapshot_hold: assert property (state == two_wire_pkg::ST_TX
      || (state == two_wire_pkg::ST_MACK && !tx_low) |=> $stable(snapshot))
      else $error("snapshot changed before low byte sent");

   a_half_dropped: assert property (s_stop ##1 phase == `PHASE_POINTER [*2]
      |-> !reg_write.valid)
      else $error("write issued after a dropped half word");

endmodule

// file: testbench/bus_master_model.sv
`timescale 1ns/1ns
// bus master: pulls clock or data low, or lets go; pull-ups supply the high level
module bus_master_model (
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   int q = 31; // quarter bit in ns; 4q+1 gives the 125 ns link clock
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // one clock pulse; data moves only while the clock is low, q after its fall
   task automatic bit_cyc(input logic pull, output logic seen);
      sda_low = pull;
      #q scl_low = 1'b0;
      #q seen = sda;
      #(q + 1) scl_low = 1'b1;
      #q;
   endtask
   // start and repeated start alike: data falls while the clock is high
   task automatic start();
      sda_low = 1'b0;
      #q scl_low = 1'b0;
      #(2 * q) sda_low = 1'b1;
      #(2 * q) scl_low = 1'b1;
      #q;
   endtask
   // stop: data rises while the clock is high, then the bus idles high
   task automatic stop();
      sda_low = 1'b1;
      #q scl_low = 1'b0;
      #(2 * q) sda_low = 1'b0;
      #(2 * q);
   endtask
   // one unit: eight bits msb first, then the slave's acknowledge
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(!b[i], s);
      end
      bit_cyc(1'b0, s);
      ack = !s;
   endtask
   // receive a unit; ack high pulls data low in the ninth bit
   task automatic recv(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b0, b[i]);
      end
      bit_cyc(ack, s);
   endtask
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`include "two_wire_cfg.svh"
module tb_top;
   logic clk;
   logic resetn;
   logic iface_select_strap;
   logic addr_strap_first;
   logic addr_strap_second;
   logic addr_strap_third;
   logic m_scl_low;
   logic m_sda_low;
   logic sda_out;
   logic sda_oe;
   logic four_wire_enable;
   logic hs_mode;
   logic [7:0] reg_addr;
   logic [15:0] mem [256];
   two_wire_pkg::reg_write_t reg_write;
   wire scl;
   wire sda;
   int n_mismatch = 0;
   int checked = 0;
   int n_wr = 0;
   int cycles = 0;
   logic [7:0] w_addr;
   logic [15:0] w_data;
   logic ack;
   logic [7:0] rb;

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // open-drain wires: low if anyone pulls, otherwise the pull-up wins
   assign scl = !m_scl_low;
   assign sda = !(sda_oe | m_sda_low);

   two_wire_register_slave DUT (
      .clk(clk),
      .resetn(resetn),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .iface_select_strap(iface_select_strap),
      .addr_strap_first(addr_strap_first),
      .addr_strap_second(addr_strap_second),
      .addr_strap_third(addr_strap_third),
      .four_wire_enable(four_wire_enable),
      .hs_mode(hs_mode),
      .reg_addr(reg_addr),
      .reg_rdata(mem[reg_addr]),
      .reg_write(reg_write)
   );
   bus_master_model master (.sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));

   // register file: writes land on the pulse; also the hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (reg_write.valid === 1'b1) begin
         n_wr <= n_wr + 1;
         w_addr <= reg_write.addr;
         w_data <= reg_write.data;
         mem[reg_write.addr] <= reg_write.data;
      end
      if (cycles == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic put(input logic [7:0] b, input logic exp, input string m);
      master.send(b, ack);
      chk(ack === exp, m);
   endtask
   // expected address per strap setting {first, second, third}
   function automatic logic [6:0] own_addr(input logic [2:0] k);
      case (k)
         3'h0: return `ADDR_LOW_00;
         3'h1: return `ADDR_LOW_01;
         3'h2: return `ADDR_LOW_10;
         3'h3: return `ADDR_LOW_11;
         default: return {`ADDR_HIGH_PREFIX, k[1:0]};
      endcase
   endfunction

   task automatic t_write(input logic [7:0] p, input logic [15:0] d);
      int n0;
      n0 = n_wr;
      master.start();
      put(8'hC2, 1'b1, "write address");
      put(p, 1'b1, "pointer byte");
      put(d[15:8], 1'b1, "high byte");
      chk(n_wr === n0, "update before low byte");
      put(d[7:0], 1'b1, "low byte");
      master.stop();
      chk(n_wr === n0 + 1 && w_addr === p && w_data === d, "word write");
   endtask
   // two words chained in one transfer
   task automatic t_multi();
      int n0;
      n0 = n_wr;
      master.start();
      put(8'hC2, 1'b1, "write address");
      for (int k = 0; k < 2; k++) begin
         put(8'h20 + k[7:0], 1'b1, "chained pointer");
         put(k ? 8'h33 : 8'h11, 1'b1, "chained high");
         put(k ? 8'h44 : 8'h22, 1'b1, "chained low");
      end
      master.stop();
      chk(n_wr === n0 + 2 && mem[8'h20] === 16'h1122, "first chained word");
      chk(mem[8'h21] === 16'h3344, "second chained word");
   endtask
   // transfer ends after the high byte: nothing written, pointer taken
   task automatic t_partial();
      int n0;
      n0 = n_wr;
      master.start();
      put(8'hC2, 1'b1, "write address");
      put(8'h30, 1'b1, "pointer byte");
      put(8'h55, 1'b1, "lone high byte");
      master.stop();
      chk(n_wr === n0, "half word written");
      chk(reg_addr === 8'h30, "pointer set");
   endtask
   // register changes after the high byte; low byte must come from the snapshot
   task automatic t_read();
      mem[8'h40] = 16'hBEEF;
      master.start();
      put(8'hC2, 1'b1, "write address");
      put(8'h40, 1'b1, "pointer byte");
      master.start();
      put(8'hC3, 1'b1, "read address");
      master.recv(1'b1, rb);
      chk(rb === 8'hBE, "read high byte");
      mem[8'h40] = 16'h1234;
      master.recv(1'b1, rb);
      chk(rb === 8'hEF, "frozen low byte");
      master.recv(1'b1, rb);
      chk(rb === 8'h12, "repeat high byte");
      master.recv(1'b0, rb);
      chk(rb === 8'h34, "repeat low byte");
      master.stop();
      chk(reg_addr === 8'h40, "pointer kept");
   endtask
   // other address, general call and a 10-bit header get no acknowledge
   task automatic t_refuse();
      logic [7:0] bad [3];
      bad = '{8'hC4, 8'h00, 8'hF0};
      for (int i = 0; i < 3; i++) begin
         master.start();
         put(bad[i], 1'b0, "refused address");
         master.stop();
      end
   endtask
   task automatic t_straps();
      for (int k = 0; k < 8; k++) begin
         tick(1);
         {addr_strap_first, addr_strap_second, addr_strap_third} = k[2:0];
         tick(8);
         master.start();
         put({own_addr(k[2:0]), 1'b0}, 1'b1, "strap address");
         master.stop();
      end
      tick(1);
      {addr_strap_first, addr_strap_second, addr_strap_third} = 3'h0;
      tick(8);
   endtask
   // master code, repeated start, word write, stop back to normal rate
   task automatic t_hs();
      master.start();
      put(8'h09, 1'b0, "master code");
      tick(8);
      chk(hs_mode === 1'b1, "high-speed entry");
      master.start();
      put(8'hC2, 1'b1, "high-speed address");
      put(8'h50, 1'b1, "high-speed pointer");
      put(8'hA5, 1'b1, "high-speed high");
      put(8'h5A, 1'b1, "high-speed low");
      chk(hs_mode === 1'b1 && w_data === 16'hA55A, "high-speed write");
      master.stop();
      tick(8);
      chk(hs_mode === 1'b0, "high-speed exit");
   endtask
   // strap high hands the pins to the other port
   task automatic t_select();
      tick(1);
      iface_select_strap = 1'b1;
      tick(8);
      chk(four_wire_enable === 1'b1, "other port enabled");
      master.start();
      put(8'hC2, 1'b0, "port disabled");
      master.stop();
      tick(1);
      iface_select_strap = 1'b0;
      tick(8);
      chk(four_wire_enable === 1'b0, "port enabled again");
   endtask

   initial begin
      resetn = 1'b0;
      iface_select_strap = 1'b0;
      addr_strap_first = 1'b0;
      addr_strap_second = 1'b0;
      addr_strap_third = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      tick(4);
      chk(sda_oe === 1'b0 && sda_out === 1'b0 && hs_mode === 1'b0, "idle outputs");
      chk(reg_addr === 8'h00 && reg_write === '0, "reset pointer");
      t_write(8'h12, 16'hABCD);
      t_multi();
      t_partial();
      t_read();
      t_refuse();
      t_straps();
      t_hs();
      t_select();
      master.q = 625; // slower 400 kbps bit time
      t_write(8'h13, 16'h0FF0);
      report_and_stop();
   end
endmodule
